/* File: logic/fifo_port_pkg.sv */
// constants shared by the byte-wide fifo port and its output buffer
// assumes a single 40 MHz clock; all times are converted to cycles here
package fifo_port_pkg;

  // ---------------------------------------------------------------
  // data path sizes
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [9:0] TX_DEPTH = 10'h180; // 384 bytes toward the host
  localparam logic [9:0] RX_DEPTH = 10'h080; // 128 bytes from the host
  localparam int TX_PTR_W = 9;
  localparam int RX_PTR_W = 7;
  localparam logic [8:0] TX_LAST = 9'h17F;
  localparam logic [8:0] RX_LAST = 9'h07F;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TX_RECOVER_NS = 50; // flag stays high while a byte is stored
  localparam int RX_GAP_NS = 80; // flag stays high after a read strobe ends
  localparam int RST_OUT_NS = 10000; // stretch of the reset output
  localparam int TX_RECOVER_CYC = (TX_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_GAP_CYC = (RX_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_OUT_CYC = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic TX_SPACE_N_RST = 1'b1;
  localparam logic RX_AVAIL_N_RST = 1'b1;
  localparam logic DATA_OE_N_RST = 1'b1;
  localparam logic RESET_OUT_N_RST = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // read strobe sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DRIVE = 2'b01,
    RD_GAP = 2'b10
  } rd_state_t;

endpackage

/* File: logic/two_entry_buffer.sv */
// two-entry valid/ready buffer between the transmit store and the usb engine
// assumes the consumer may hold ready low for any number of cycles
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer
  import fifo_port_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  // filling side
  input wire logic [fifo_port_pkg::DATA_W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // draining side
  output logic [fifo_port_pkg::DATA_W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  logic [DATA_W-1:0] spare_q;
  logic spare_valid_q;
  logic take;
  logic give;

  // ready only while the spare slot is free, so a stall loses nothing
  assign in_ready_o = ~spare_valid_q;
  assign take = in_valid_i & ~spare_valid_q;
  assign give = out_valid_o & out_ready_i;

  // head entry drives the output straight from a flop
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_data_o <= DATA_RST;
      out_valid_o <= 1'b0;
    end
    else if (clear_i)
    begin
      out_data_o <= DATA_RST;
      out_valid_o <= 1'b0;
    end
    else if (!out_valid_o || give)
    begin
      if (spare_valid_q)
      begin
        out_data_o <= spare_q;
        out_valid_o <= 1'b1;
      end
      else
      begin
        out_data_o <= in_data_i;
        out_valid_o <= take;
      end
    end
  end

  // spare entry catches a word when the head is stalled
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      spare_q <= DATA_RST;
      spare_valid_q <= 1'b0;
    end
    else if (clear_i)
    begin
      spare_q <= DATA_RST;
      spare_valid_q <= 1'b0;
    end
    else if (spare_valid_q)
    begin
      if (!out_valid_o || give)
        spare_valid_q <= 1'b0;
    end
    else if (take && out_valid_o && !give)
    begin
      spare_q <= in_data_i;
      spare_valid_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: logic/usb_parallel_fifo_handshake_port.sv */
// byte-wide parallel fifo port of a usb bridge, peripheral facing side
// assumes the usb engine moves bytes in and out on valid/ready streams
// and that peripheral strobes are synchronous to clock_i
//
// Functional notes
// - tx_space_n stays high while the 384-byte store is full or busy storing.
// - tx_space_n goes high after every written byte, then returns low unless the store is full.
// - rx_avail_n is low while at least one received byte waits.
// - rx_avail_n goes high after every read; low again only with another byte.
// - transmit store holds 384 bytes, receive store holds 128 bytes.
// - no baud-rate pacing; bytes move at full clock rate always.
// - internal power-on reset plus active-low external reset input.
// - reset_out_n is driven low from the power-on reset, then released.
// - send-immediate strobe makes the next bulk-in request send all pending data.
`timescale 1ns/1ps
`default_nettype none

module usb_parallel_fifo_handshake_port
  import fifo_port_pkg::*;
(
  // clock and power-on reset
  input wire logic clock_i,
  input wire logic rst_i,
  // external reset and reset output
  input wire logic ext_reset_n_i,
  output logic reset_out_n_o,
  // peripheral data lines, split into in, out and enable
  input wire logic [fifo_port_pkg::DATA_W-1:0] data_i,
  output logic [fifo_port_pkg::DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  // peripheral strobes and flags
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic send_now_n_i,
  output logic tx_space_n_o,
  output logic rx_avail_n_o,
  // bytes from the usb host
  input wire logic [fifo_port_pkg::DATA_W-1:0] usb_rx_data_i,
  input wire logic usb_rx_valid_i,
  output logic usb_rx_ready_o,
  // bytes toward the usb host
  output logic [fifo_port_pkg::DATA_W-1:0] usb_tx_data_o,
  output logic usb_tx_valid_o,
  input wire logic usb_tx_ready_i,
  // bulk-in request and send-immediate handling
  input wire logic bulk_in_req_i,
  output logic flush_pending_o,
  output logic flush_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // wrapping pointer step, shared by both stores
  function automatic logic [8:0] ptr_inc(input logic [8:0] p, input logic [8:0] last);
    ptr_inc = (p == last) ? 9'h000 : p + 9'h001;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic clr;
  logic wr_n_q, rd_n_q, send_now_n_q;
  logic wr_fall, rd_fall, send_fall;
  logic [DATA_W-1:0] tx_mem [0:383];
  logic [TX_PTR_W-1:0] tx_wr_q, tx_rd_q;
  logic [9:0] tx_cnt_q, tx_cnt_d;
  logic tx_push, tx_pop, buf_ready;
  logic [3:0] tx_hold_q;
  logic [DATA_W-1:0] rx_mem [0:127];
  logic [RX_PTR_W-1:0] rx_wr_q, rx_rd_q;
  logic [9:0] rx_cnt_q, rx_cnt_d;
  logic rx_push, rx_pop;
  rd_state_t rd_state_q;
  logic [3:0] rx_gap_q;
  logic [8:0] rst_cnt_q;

  // external reset acts as a synchronous clear of the port, except the strobe edge flops and the reset output
  assign clr = ~ext_reset_n_i;

  // ---------------------------------------------------------------
  // strobe edges
  // ---------------------------------------------------------------
  // previous strobe levels; inputs are already synchronous
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      send_now_n_q <= 1'b1;
    end
    else
    begin
      wr_n_q <= wr_n_i;
      rd_n_q <= rd_n_i;
      send_now_n_q <= send_now_n_i;
    end
  end

  assign wr_fall = wr_n_q & ~wr_n_i;
  assign rd_fall = rd_n_q & ~rd_n_i;
  assign send_fall = send_now_n_q & ~send_now_n_i;

  // ---------------------------------------------------------------
  // transmit store, 384 bytes
  // ---------------------------------------------------------------
  // a write while the flag is high never reaches the store
  assign tx_push = wr_fall & ~tx_space_n_o;
  // bytes leave as soon as the buffer takes them, with no rate pacing
  assign tx_pop = (tx_cnt_q != 10'h000) & buf_ready;
  assign tx_cnt_d = tx_cnt_q + {9'h000, tx_push} - {9'h000, tx_pop};

  // store the byte on the falling write strobe
  always_ff @(posedge clock_i)
  begin
    if (tx_push)
      tx_mem[tx_wr_q] <= data_i;
  end

  // pointers and fill count
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_wr_q <= '0;
      tx_rd_q <= '0;
      tx_cnt_q <= 10'h000;
    end
    else if (clr)
    begin
      tx_wr_q <= '0;
      tx_rd_q <= '0;
      tx_cnt_q <= 10'h000;
    end
    else
    begin
      if (tx_push)
        tx_wr_q <= ptr_inc(tx_wr_q, TX_LAST);
      if (tx_pop)
        tx_rd_q <= ptr_inc(tx_rd_q, TX_LAST);
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // space flag: high on every write for the storing time, then low if not full
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_space_n_o <= TX_SPACE_N_RST;
      tx_hold_q <= 4'h0;
    end
    else if (clr)
    begin
      tx_space_n_o <= TX_SPACE_N_RST;
      tx_hold_q <= 4'h0;
    end
    else if (tx_push)
    begin
      tx_space_n_o <= 1'b1;
      tx_hold_q <= 4'(TX_RECOVER_CYC);
    end
    else if (tx_hold_q != 4'h0)
      tx_hold_q <= tx_hold_q - 4'h1;
    else
      tx_space_n_o <= (tx_cnt_q >= TX_DEPTH);
  end

  // the buffer absorbs a stall by the usb engine without dropping a byte
  two_entry_buffer u_tx_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(clr),
    .in_data_i(tx_mem[tx_rd_q]),
    .in_valid_i(tx_cnt_q != 10'h000),
    .in_ready_o(buf_ready),
    .out_data_o(usb_tx_data_o),
    .out_valid_o(usb_tx_valid_o),
    .out_ready_i(usb_tx_ready_i)
  );

  // ---------------------------------------------------------------
  // receive store, 128 bytes
  // ---------------------------------------------------------------
  assign rx_push = usb_rx_valid_i & usb_rx_ready_o;
  // the flag is low only with a byte present, so a pop is never empty
  assign rx_pop = (rd_state_q == RD_IDLE) & rd_fall & ~rx_avail_n_o;
  assign rx_cnt_d = rx_cnt_q + {9'h000, rx_push} - {9'h000, rx_pop};

  // store bytes from the usb engine
  always_ff @(posedge clock_i)
  begin
    if (rx_push)
      rx_mem[rx_wr_q] <= usb_rx_data_i;
  end

  // pointers, count and registered ready toward the usb engine
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      rx_cnt_q <= 10'h000;
      usb_rx_ready_o <= 1'b0;
    end
    else if (clr)
    begin
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      rx_cnt_q <= 10'h000;
      usb_rx_ready_o <= 1'b0;
    end
    else
    begin
      if (rx_push)
        rx_wr_q <= RX_PTR_W'(ptr_inc({2'b00, rx_wr_q}, RX_LAST));
      if (rx_pop)
        rx_rd_q <= RX_PTR_W'(ptr_inc({2'b00, rx_rd_q}, RX_LAST));
      rx_cnt_q <= rx_cnt_d;
      // count moves by one at most, so next-count decides next cycle's ready
      usb_rx_ready_o <= (rx_cnt_d < RX_DEPTH);
    end
  end

  // read sequencer: drive during the strobe, then a gap before the flag drops
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_state_q <= RD_IDLE;
      rx_gap_q <= 4'h0;
      rx_avail_n_o <= RX_AVAIL_N_RST;
      data_o <= DATA_RST;
      data_oe_n_o <= DATA_OE_N_RST;
    end
    else if (clr)
    begin
      rd_state_q <= RD_IDLE;
      rx_gap_q <= 4'h0;
      rx_avail_n_o <= RX_AVAIL_N_RST;
      data_o <= DATA_RST;
      data_oe_n_o <= DATA_OE_N_RST;
    end
    else
    begin
      case (rd_state_q)
        RD_IDLE:
        begin
          if (rd_fall)
          begin
            // a strobe with the flag high drives the last byte again
            if (rx_pop)
              data_o <= rx_mem[rx_rd_q];
            rx_avail_n_o <= 1'b1;
            data_oe_n_o <= 1'b0;
            rd_state_q <= RD_DRIVE;
          end
          else
            rx_avail_n_o <= (rx_cnt_q == 10'h000);
        end
        RD_DRIVE:
        begin
          if (rd_n_i)
          begin
            data_oe_n_o <= 1'b1;
            rx_gap_q <= 4'(RX_GAP_CYC);
            rd_state_q <= RD_GAP;
          end
        end
        RD_GAP:
        begin
          if (rx_gap_q <= 4'h1)
            rd_state_q <= RD_IDLE;
          else
            rx_gap_q <= rx_gap_q - 4'h1;
        end
        default:
        begin
          rd_state_q <= RD_IDLE;
          data_oe_n_o <= 1'b1;
          rx_avail_n_o <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // send immediate
  // ---------------------------------------------------------------
  // a new strobe in the same cycle as the request keeps the flag set
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flush_pending_o <= 1'b0;
      flush_o <= 1'b0;
    end
    else if (clr)
    begin
      flush_pending_o <= 1'b0;
      flush_o <= 1'b0;
    end
    else
    begin
      flush_o <= bulk_in_req_i & flush_pending_o;
      if (send_fall)
        flush_pending_o <= 1'b1;
      else if (bulk_in_req_i)
        flush_pending_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // reset output
  // ---------------------------------------------------------------
  // held low from power-on reset for a fixed stretch; the external reset
  // input does not reach it, so attached logic sees only the clean one
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_cnt_q <= 9'h000;
      reset_out_n_o <= RESET_OUT_N_RST;
    end
    else if (rst_cnt_q != 9'(RST_OUT_CYC))
      rst_cnt_q <= rst_cnt_q + 9'h001;
    else
      reset_out_n_o <= 1'b1;
  end

endmodule

`default_nettype wire

/* File: test/periph_model.sv */
// peripheral logic model on the byte-wide port
// assumes the bench calls its tasks; strobes move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module periph_model
  import fifo_port_pkg::*;
(
  // clock
  input wire logic clock_i,
  // flags and device drive
  input wire logic tx_space_n_i,
  input wire logic rx_avail_n_i,
  input wire logic [fifo_port_pkg::DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // strobes and resolved data lines
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [fifo_port_pkg::DATA_W-1:0] bus_o
);
  logic drive_q;
  logic [DATA_W-1:0] val_q;

  // undriven lines show the inverse byte so a stale value never passes
  assign bus_o = !dev_oe_n_i ? dev_data_i : (drive_q ? val_q : ~val_q);

  initial
  begin
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    drive_q = 1'b0;
    val_q = 8'h00;
  end

  // obey low means the space flag is ignored on purpose
  task automatic write(input logic [DATA_W-1:0] b, input bit obey, output bit ok);
    int n;
    n = 0;
    @(negedge clock_i);
    while (obey && tx_space_n_i !== 1'b0 && n < 50)
    begin
      @(negedge clock_i);
      n++;
    end
    ok = (n < 50);
    if (ok)
    begin
      val_q = b;
      drive_q = 1'b1;
      wr_n_o = 1'b0;
      @(negedge clock_i);
      wr_n_o = 1'b1;
      drive_q = 1'b0;
    end
  endtask

  // one byte per low period of the receive flag
  task automatic read(output logic [DATA_W-1:0] b, output bit ok);
    int n;
    n = 0;
    b = 8'h00;
    @(negedge clock_i);
    while (rx_avail_n_i !== 1'b0 && n < 50)
    begin
      @(negedge clock_i);
      n++;
    end
    ok = (n < 50);
    if (ok)
    begin
      rd_n_o = 1'b0;
      repeat (2) @(negedge clock_i);
      b = bus_o;
      rd_n_o = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/port_checker.sv */
// concurrent checks on the pins of the byte-wide fifo port
// assumes it is bound onto the port module and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
module port_checker
  import fifo_port_pkg::*;
(
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic reset_out_n_o,
  // peripheral side
  input wire logic data_oe_n_o,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic send_now_n_i,
  input wire logic tx_space_n_o,
  input wire logic rx_avail_n_o,
  // usb side
  input wire logic [fifo_port_pkg::DATA_W-1:0] usb_tx_data_o,
  input wire logic usb_tx_valid_o,
  input wire logic usb_tx_ready_i,
  input wire logic bulk_in_req_i,
  input wire logic flush_pending_o,
  input wire logic flush_o
);
  // ------------------
  // helpers
  // ------------------
  int unsigned up_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !ext_reset_n_i);

  // cycles since power-on release; saturates so it never wraps in a long run
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      up_q <= 0;
    else if (up_q < 1000)
      up_q <= up_q + 1;
  end

  sequence s_wr_taken;
    !tx_space_n_o && $fell(wr_n_i);
  endsequence
  sequence s_flush_pulse;
    flush_o ##1 !flush_o;
  endsequence

  // ------------------
  // properties
  // ------------------
  property p_wr_busy;
    s_wr_taken |=> tx_space_n_o [*3];
  endproperty
  property p_tx_first;
    s_wr_taken ##0 !usb_tx_valid_o |-> ##[1:6] usb_tx_valid_o;
  endproperty
  property p_tx_hold;
    usb_tx_valid_o && !usb_tx_ready_i |=> usb_tx_valid_o && $stable(usb_tx_data_o);
  endproperty
  property p_rd_answer;
    !rx_avail_n_o && $fell(rd_n_i) |=> rx_avail_n_o && !data_oe_n_o;
  endproperty
  property p_rd_gap;
    $rose(rd_n_i) && !data_oe_n_o |=> data_oe_n_o ##0 rx_avail_n_o [*4];
  endproperty
  property p_oe_only;
    !data_oe_n_o |-> !$past(rd_n_i);
  endproperty
  property p_send_now;
    $fell(send_now_n_i) |=> flush_pending_o;
  endproperty
  property p_flush;
    bulk_in_req_i && flush_pending_o |=> s_flush_pulse;
  endproperty
  property p_ext_rst;
    @(posedge clock_i) disable iff (rst_i)
    !ext_reset_n_i |=> tx_space_n_o && rx_avail_n_o && data_oe_n_o && !usb_tx_valid_o;
  endproperty
  property p_rst_out;
    @(posedge clock_i) disable iff (rst_i)
    (up_q + 1 < RST_OUT_CYC || up_q > RST_OUT_CYC + 1) |->
      reset_out_n_o == (up_q > RST_OUT_CYC);
  endproperty

  a_wr_busy: assert property (p_wr_busy)
    else $error("space flag fell too soon after a write");
  a_tx_first: assert property (p_tx_first)
    else $error("written byte did not reach the usb side in time");
  a_tx_hold: assert property (p_tx_hold)
    else $error("usb byte changed while stalled");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered with flag high and drive on");
  a_rd_gap: assert property (p_rd_gap)
    else $error("drive or flag wrong after read strobe end");
  a_oe_only: assert property (p_oe_only)
    else $error("data lines driven outside a read strobe");
  a_send_now: assert property (p_send_now)
    else $error("send strobe not recorded");
  a_flush: assert property (p_flush)
    else $error("flush pulse missing on bulk request");
  a_ext_rst: assert property (p_ext_rst)
    else $error("external reset did not clear the port");
  a_rst_out: assert property (p_rst_out)
    else $error("reset output stretch wrong");
endmodule

bind usb_parallel_fifo_handshake_port port_checker u_chk (.clock_i, .rst_i, .ext_reset_n_i,
  .reset_out_n_o, .data_oe_n_o, .wr_n_i, .rd_n_i, .send_now_n_i, .tx_space_n_o, .rx_avail_n_o,
  .usb_tx_data_o, .usb_tx_valid_o, .usb_tx_ready_i, .bulk_in_req_i, .flush_pending_o, .flush_o);
`default_nettype wire

/* File: test/usb_parallel_fifo_handshake_port_tb.sv */
// self-checking bench for the byte-wide fifo port
// assumes the peripheral model drives strobes and the bench plays the usb engine
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_handshake_port_tb;
  import fifo_port_pkg::*;
  logic clock_i, rst_i, ext_reset_n_i, send_now_n_i, bulk_in_req_i, usb_tx_ready_i;
  logic usb_rx_valid_i, wr_n, rd_n, data_oe_n_o, reset_out_n_o, tx_space_n_o;
  logic rx_avail_n_o, usb_rx_ready_o, usb_tx_valid_o, flush_pending_o, flush_o;
  logic [DATA_W-1:0] usb_rx_data_i, usb_tx_data_o, data_o, bus;
  int bad_count, n_compared;

  usb_parallel_fifo_handshake_port DUT (.clock_i, .rst_i, .ext_reset_n_i, .reset_out_n_o,
    .data_i(bus), .data_o, .data_oe_n_o, .wr_n_i(wr_n), .rd_n_i(rd_n), .send_now_n_i,
    .tx_space_n_o, .rx_avail_n_o, .usb_rx_data_i, .usb_rx_valid_i, .usb_rx_ready_o,
    .usb_tx_data_o, .usb_tx_valid_o, .usb_tx_ready_i, .bulk_in_req_i, .flush_pending_o,
    .flush_o);
  periph_model u_per (.clock_i, .tx_space_n_i(tx_space_n_o), .rx_avail_n_i(rx_avail_n_o),
    .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o), .wr_n_o(wr_n), .rd_n_o(rd_n), .bus_o(bus));

  // ------------------
  // compare and close
  // ------------------
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------
  // scenarios
  // ------------------
  // usb host byte: held until the port takes it, or given up after 20 cycles
  task automatic push(input logic [DATA_W-1:0] b, output bit ok);
    int n;
    n = 0;
    @(negedge clock_i);
    usb_rx_data_i = b;
    usb_rx_valid_i = 1'b1;
    // ready is a register, so its level here is what the next edge samples
    while (usb_rx_ready_o !== 1'b1 && n < 20)
    begin
      @(negedge clock_i);
      n++;
    end
    ok = (usb_rx_ready_o === 1'b1);
    @(negedge clock_i);
    usb_rx_valid_i = 1'b0;
  endtask
  task automatic t_reset_values();
    chk_val({4'h0, tx_space_n_o, rx_avail_n_o, data_oe_n_o, reset_out_n_o}, 8'h06);
    repeat (RST_OUT_CYC) @(negedge clock_i);
    chk_val({7'h00, reset_out_n_o}, 8'h01);
  endtask
  // fill with the usb side stalled, try a refused write, then drain in order
  task automatic t_tx_fill();
    int n, k;
    bit ok;
    n = 0;
    k = 0;
    ok = 1'b1;
    while (ok && n < 400)
    begin
      u_per.write(n[7:0], 1'b1, ok);
      if (ok)
        n++;
      if (n == 1)
        chk_val({7'h00, tx_space_n_o}, 8'h01);
    end
    chk_num(n, int'(TX_DEPTH) + 2);
    chk_val({7'h00, tx_space_n_o}, 8'h01);
    u_per.write(8'hEE, 1'b0, ok);
    @(negedge clock_i);
    usb_tx_ready_i = 1'b1;
    // look between edges: a byte seen valid here is taken at the next edge
    repeat (450)
    begin
      if (usb_tx_valid_o === 1'b1)
      begin
        chk_val(usb_tx_data_o, k[7:0]);
        k++;
      end
      @(negedge clock_i);
    end
    chk_num(k, n);
    @(negedge clock_i);
    chk_val({7'h00, tx_space_n_o}, 8'h00);
  endtask
  // fill the receive store until refused, then read every byte back
  task automatic t_rx();
    int n;
    bit ok;
    logic [DATA_W-1:0] b;
    n = 0;
    ok = 1'b1;
    while (ok && n < 200)
    begin
      push(n[7:0] ^ 8'h5A, ok);
      if (ok)
        n++;
    end
    chk_num(n, int'(RX_DEPTH));
    chk_val({7'h00, rx_avail_n_o}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      u_per.read(b, ok);
      chk_val(b, i[7:0] ^ 8'h5A);
    end
    repeat (12) @(negedge clock_i);
    chk_val({7'h00, rx_avail_n_o}, 8'h01);
  endtask
  task automatic pulse_req();
    @(negedge clock_i);
    bulk_in_req_i = 1'b1;
    @(negedge clock_i);
    bulk_in_req_i = 1'b0;
  endtask
  task automatic t_flush();
    pulse_req();
    chk_val({6'h00, flush_o, flush_pending_o}, 8'h00);
    @(negedge clock_i);
    send_now_n_i = 1'b0;
    @(negedge clock_i);
    send_now_n_i = 1'b1;
    chk_val({6'h00, flush_o, flush_pending_o}, 8'h01);
    pulse_req();
    chk_val({6'h00, flush_o, flush_pending_o}, 8'h02);
    @(negedge clock_i);
    chk_val({6'h00, flush_o, flush_pending_o}, 8'h00);
    // strobe and request on one edge: the new strobe must stay pending
    @(negedge clock_i);
    send_now_n_i = 1'b0;
    bulk_in_req_i = 1'b1;
    @(negedge clock_i);
    send_now_n_i = 1'b1;
    bulk_in_req_i = 1'b0;
    chk_val({6'h00, flush_o, flush_pending_o}, 8'h01);
  endtask
  // a byte waits each way (receive store, and output buffer toward the host) when the external reset arrives
  task automatic t_ext_reset();
    bit ok;
    usb_tx_ready_i = 1'b0;
    u_per.write(8'hC3, 1'b1, ok);
    push(8'h3C, ok);
    repeat (10) @(negedge clock_i);
    ext_reset_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk_val({5'h00, usb_tx_valid_o, rx_avail_n_o, reset_out_n_o}, 8'h03);
    ext_reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk_val({5'h00, usb_tx_valid_o, rx_avail_n_o, tx_space_n_o}, 8'h02);
  endtask

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // main sequence; inputs move on falling edges only
  initial
  begin
    rst_i = 1'b1;
    ext_reset_n_i = 1'b1;
    send_now_n_i = 1'b1;
    bulk_in_req_i = 1'b0;
    usb_tx_ready_i = 1'b0;
    usb_rx_valid_i = 1'b0;
    usb_rx_data_i = 8'h00;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    t_reset_values();
    t_tx_fill();
    t_rx();
    t_flush();
    t_ext_reset();
    complete_run();
  end

  // hang guard, well past the few thousand cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
